// ### hdl/uopf_top.sv
`timescale 1ns/1ns
module uopf_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // bus line state pins
    input  wire logic        line_k_state,
    input  wire logic        line_se0,
    input  wire logic        line_idle,
    input  wire logic        line_activity,
    // events from the protocol engine, same clock
    input  wire logic        stall_event,
    input  wire logic        token_done_event,
    input  wire logic        sof_event,
    input  wire logic        bus_reset_event,
    input  wire logic        detach_event,
    input  wire logic        attach_seen,
    input  wire logic [7:0]  error_conditions,
    input  wire logic [7:0]  error_interrupt_enable_reg,
    input  wire logic        engine_active,
    input  wire logic        activity_notified,
    // outputs
    output logic             status_fifo_advance,
    output logic             usb_clk_gate_en,
    output logic             xcvr_low_power,
    output logic             pins_owned,
    output logic             analog_enable,
    output logic             sleep_block,
    output logic [7:0]       flags_out
);
    typedef enum logic [2:0] {
        UOPF_OFF   = 3'b001,
        UOPF_ON    = 3'b010,
        UOPF_DRAIN = 3'b100
    } uopf_state_t;

    uopf_state_t state_reg;
    uopf_state_t state_next;
    logic [2:0]  drain_reg;
    logic        enable_reg;
    logic        suspend_reg;
    logic        guard_reg;
    logic        pending_reg;
    logic        host_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        k_s;
    logic        se0_s;
    logic        idle_s;
    logic        act_s;
    logic        act_d_reg;
    logic        k_done;
    logic        idle_done;
    logic        quiet_done;
    logic        k_done_d_reg;
    logic        idle_done_d_reg;
    logic        attach_d_reg;
    logic        busy;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a[3:2] == off[3:2]);
    endfunction : hit

    uopf_sync #(.W(4)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({line_k_state, line_se0, line_idle, line_activity}),
        .q       ({k_s, se0_s, idle_s, act_s})
    );

    uopf_timer #(.LIMIT(uopf_pkg::K_STATE_CYCLES)) u_k_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (k_s),
        .done    (k_done)
    );

    uopf_timer #(.LIMIT(uopf_pkg::IDLE_CYCLES)) u_idle_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (idle_s),
        .done    (idle_done)
    );

    uopf_timer #(.LIMIT(uopf_pkg::ATTACH_CYCLES)) u_quiet_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (!act_s),
        .done    (quiet_done)
    );

    // axi write: address and data taken in either order, response after both
    wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire wr_pwr  = wr_fire && hit(awaddr_reg, uopf_pkg::OFF_POWER_CONTROL) && wstrb_reg[0];
    wire wr_flg  = wr_fire && hit(awaddr_reg, uopf_pkg::OFF_INTERRUPT_FLAGS) && wstrb_reg[0];
    wire wr_ctl  = wr_fire && hit(awaddr_reg, uopf_pkg::OFF_BUS_EVENT_CTRL) && wstrb_reg[0];
    wire wr_bad  = awaddr_reg[3:2] == 2'b11;
    wire rd_bad  = s_axi_araddr[3:2] == 2'b11;

    assign s_axi_awready = !aw_got_reg;
    assign s_axi_wready  = !w_got_reg;
    assign s_axi_arready = !s_axi_rvalid;

    // busy while running, draining after disable, or while engine_active is high
    assign busy = (state_reg != UOPF_OFF) || engine_active;

    wire attach_ok = host_reg && quiet_done && !se0_s && attach_seen;
    wire bit0_ev   = host_reg ? detach_event : bus_reset_event;
    wire err_ev    = |(error_conditions & error_interrupt_enable_reg);

    assign set_vec = enable_reg ? {stall_event,
                                   attach_ok && !attach_d_reg,
                                   k_done && !k_done_d_reg,
                                   idle_done && !idle_done_d_reg,
                                   token_done_event,
                                   sof_event,
                                   err_ev,
                                   bit0_ev} : 8'h00;
    assign clr_vec    = wr_flg ? wdata_reg[7:0] : 8'h00;
    // set wins over clear; zeros in the write leave flags alone
    assign flags_next = (flags_reg & ~clr_vec) | set_vec;
    assign status_fifo_advance = clr_vec[uopf_pkg::FLAG_TOKEN_DONE]
                                 && flags_reg[uopf_pkg::FLAG_TOKEN_DONE];

    assign usb_clk_gate_en = enable_reg && !suspend_reg;
    assign xcvr_low_power  = suspend_reg || !enable_reg;
    assign pins_owned      = enable_reg;
    assign analog_enable   = enable_reg;
    assign sleep_block     = guard_reg && (act_s || pending_reg);
    assign flags_out       = flags_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            UOPF_OFF:   if (enable_reg) state_next = UOPF_ON;
            UOPF_ON:    if (!enable_reg) state_next = UOPF_DRAIN;
            UOPF_DRAIN: if (enable_reg) state_next = UOPF_ON;
                        else if (drain_reg == 3'(uopf_pkg::BUSY_DRAIN_CYCLES))
                            state_next = UOPF_OFF;
            default:    state_next = UOPF_OFF;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= UOPF_OFF;
            drain_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            drain_reg <= (state_reg == UOPF_DRAIN) ? drain_reg + 3'h1 : 3'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg  <= 32'h0;
            wstrb_reg  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad ? 2'h2 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg  <= 1'b0;
            suspend_reg <= 1'b0;
            guard_reg   <= 1'b0;
            host_reg    <= 1'b0;
            pending_reg <= 1'b0;
            flags_reg   <= uopf_pkg::FLAGS_RESET;
            act_d_reg   <= 1'b0;
            k_done_d_reg    <= 1'b0;
            idle_done_d_reg <= 1'b0;
            attach_d_reg    <= 1'b0;
        end
        else
        begin
            if (wr_pwr)
            begin
                enable_reg  <= wdata_reg[uopf_pkg::PWR_ENABLE_BIT];
                suspend_reg <= wdata_reg[uopf_pkg::PWR_SUSPEND_BIT];
                guard_reg   <= wdata_reg[uopf_pkg::PWR_GUARD_BIT];
            end
            if (wr_ctl)
                host_reg <= wdata_reg[uopf_pkg::CTRL_HOST_BIT];
            // new activity edge sets; notification clears; writes never touch it
            if (enable_reg && act_s && !act_d_reg)
                pending_reg <= 1'b1;
            else if (activity_notified)
                pending_reg <= 1'b0;
            flags_reg       <= flags_next;
            act_d_reg       <= act_s;
            k_done_d_reg    <= k_done;
            idle_done_d_reg <= idle_done;
            attach_d_reg    <= attach_ok;
        end
    end

    wire [7:0] pwr_rd = {pending_reg, 2'b00, guard_reg, busy, 1'b0, suspend_reg, enable_reg};
    wire [7:0] rd_lo  = hit(s_axi_araddr, uopf_pkg::OFF_POWER_CONTROL)   ? pwr_rd :
                        hit(s_axi_araddr, uopf_pkg::OFF_INTERRUPT_FLAGS) ? flags_reg :
                        hit(s_axi_araddr, uopf_pkg::OFF_BUS_EVENT_CTRL)  ? {7'h0, host_reg} :
                        8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_lo};
            s_axi_rresp  <= rd_bad ? 2'h2 : 2'h0;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    sequence wr_both_s;
        aw_got_reg && w_got_reg && !s_axi_bvalid;
    endsequence

    stall_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_reg && stall_event |=> flags_reg[uopf_pkg::FLAG_STALL])
        else $error("stall flag not set");
    idle_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_reg && idle_done && !idle_done_d_reg |=> flags_reg[uopf_pkg::FLAG_IDLE])
        else $error("idle flag not set");
    flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags_reg[3] && !clr_vec[3] |=> flags_reg[3])
        else $error("token flag dropped");
    w1c_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_vec[2] && !set_vec[2] |=> !flags_reg[2])
        else $error("frame flag not cleared");
    masked_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(err_ev) && !$past(flags_reg[1]) |-> !flags_reg[1])
        else $error("masked error set flag");
    gate_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        suspend_reg |-> !usb_clk_gate_en && xcvr_low_power)
        else $error("clock runs in suspend");
    off_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable_reg |-> !pins_owned && !analog_enable)
        else $error("pins held while off");
    guard_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !guard_reg |-> !sleep_block)
        else $error("sleep blocked without guard");
    busy_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == UOPF_ON && !enable_reg |=> busy [*4])
        else $error("busy dropped early");
    read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper bits nonzero");
    pend_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        activity_notified && !(enable_reg && act_s && !act_d_reg) |=> !pending_reg)
        else $error("pending not cleared");
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_both_s |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : uopf_top

// ### hdl/uopf_pkg.sv
package uopf_pkg;
    // register byte offsets
    localparam logic [3:0]  OFF_POWER_CONTROL   = 4'h0;
    localparam logic [3:0]  OFF_INTERRUPT_FLAGS = 4'h4;
    localparam logic [3:0]  OFF_BUS_EVENT_CTRL  = 4'h8;
    // power control fields
    localparam int          PWR_ENABLE_BIT      = 0;
    localparam int          PWR_SUSPEND_BIT     = 1;
    localparam int          PWR_BUSY_BIT        = 3;
    localparam int          PWR_GUARD_BIT       = 4;
    localparam int          PWR_PENDING_BIT     = 7;
    // interrupt flag positions
    localparam int          FLAG_BUS_RESET      = 0;
    localparam int          FLAG_ERROR          = 1;
    localparam int          FLAG_FRAME_START    = 2;
    localparam int          FLAG_TOKEN_DONE     = 3;
    localparam int          FLAG_IDLE           = 4;
    localparam int          FLAG_RESUME         = 5;
    localparam int          FLAG_ATTACH         = 6;
    localparam int          FLAG_STALL          = 7;
    localparam int          FLAG_COUNT          = 8;
    // bus event control fields
    localparam int          CTRL_HOST_BIT       = 0;
    localparam logic [7:0]  FLAGS_RESET         = 8'h00;
    // timing
    localparam int          CLK_MHZ             = 100;
    localparam int          K_STATE_NS          = 2500;
    localparam int          IDLE_ATTACH_NS      = 2500;
    localparam int          IDLE_MS             = 3;
    localparam int          K_STATE_CYCLES      = (K_STATE_NS * CLK_MHZ + 999) / 1000;
    localparam int          ATTACH_CYCLES       = (IDLE_ATTACH_NS * CLK_MHZ + 999) / 1000;
    localparam int          IDLE_CYCLES         = IDLE_MS * 1000 * CLK_MHZ;
    localparam int          BUSY_DRAIN_CYCLES   = 4;
endpackage : uopf_pkg

// ### hdl/uopf_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for pin-level inputs
module uopf_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : uopf_sync

// ### hdl/uopf_timer.sv
`timescale 1ns/1ns
// counts cycles while cond holds; done is a level once the count is reached
module uopf_timer #(
    parameter int LIMIT = 4
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic cond,
    output logic      done
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);
    logic [CW-1:0] cnt_reg;

    assign done = (cnt_reg == LIM);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !cond)
            cnt_reg <= '0;
        else if (!done)
            cnt_reg <= cnt_reg + CW'(1);
    end
endmodule : uopf_timer

// ### test/uopf_partner.sv
`timescale 1ns/1ns
// far side: bus line levels and protocol engine event pulses
module uopf_partner (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] line_mode,
    input  wire logic [5:0] ev_req,
    output logic            line_k_state,
    output logic            line_se0,
    output logic            line_idle,
    output logic            line_activity,
    output logic            stall_event,
    output logic            token_done_event,
    output logic            sof_event,
    output logic            bus_reset_event,
    output logic            detach_event,
    output logic            activity_notified
);
    logic [5:0] ev_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ev_reg <= 6'h00;
        else
            ev_reg <= ev_req;
    end
    // each request is registered and comes out one cycle later, for as many cycles as it is held
    assign {activity_notified, detach_event, bus_reset_event, sof_event, token_done_event,
            stall_event} = ev_reg;
    // line modes: 0 idle, 1 k-state, 2 se0, 3 traffic
    assign line_idle     = (line_mode == 2'd0);
    assign line_k_state  = (line_mode == 2'd1);
    assign line_se0      = (line_mode == 2'd2);
    assign line_activity = (line_mode == 2'd3);
endmodule : uopf_partner

// ### test/uopf_top_test.sv
`timescale 1ns/1ns
module uopf_top_test;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, attach;
    logic        arvalid, arready, rvalid, rready, eng, host, kst, se0, idl, act;
    logic        stl, tok, sof, brst, det, ntf, adv, cg, lp, po, an, sb;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, v;
    logic [1:0]  bresp, rresp, r, mode;
    logic [7:0]  err, eie, exp, flags;
    logic [5:0]  ev;
    int          errors, num_checks, a0;
    int          adv_cnt = 0;

    uopf_top uopf_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_k_state(kst), .line_se0(se0), .line_idle(idl), .line_activity(act),
        .stall_event(stl), .token_done_event(tok), .sof_event(sof), .bus_reset_event(brst),
        .detach_event(det), .attach_seen(attach), .error_conditions(err),
        .error_interrupt_enable_reg(eie), .engine_active(eng), .activity_notified(ntf),
        .status_fifo_advance(adv), .usb_clk_gate_en(cg), .xcvr_low_power(lp),
        .pins_owned(po), .analog_enable(an), .sleep_block(sb), .flags_out(flags));

    uopf_partner uopf_partner_i (.aclk(aclk), .aresetn(aresetn), .line_mode(mode),
        .ev_req(ev), .line_k_state(kst), .line_se0(se0), .line_idle(idl),
        .line_activity(act), .stall_event(stl), .token_done_event(tok), .sof_event(sof),
        .bus_reset_event(brst), .detach_event(det), .activity_notified(ntf));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] dt);
        logic pa, pw, g;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge aclk);
            awvalid <= pa;
            wvalid <= pw;
        end while (pa || pw);
        // raised once the request is taken, so back-to-back calls never drive it twice
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            g = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!g);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        logic g;
        g = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            g = !arready;
            @(posedge aclk);
            arvalid <= g;
        end while (g);
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            g = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!g);
        rready <= 1'b0;
    endtask : rd

    task automatic pulse(input logic [5:0] e, input logic [7:0] er);
        ev <= e;
        err <= er;
        @(posedge aclk);
        ev <= 6'h00;
        err <= 8'h00;
        repeat (4) @(posedge aclk);
    endtask : pulse

    function automatic logic [7:0] flag_exp(input logic [4:0] e, input logic h,
                                            input logic [7:0] er, input logic [7:0] en);
        flag_exp = 8'h00;
        flag_exp[uopf_pkg::FLAG_STALL] = e[0];
        flag_exp[uopf_pkg::FLAG_TOKEN_DONE] = e[1];
        flag_exp[uopf_pkg::FLAG_FRAME_START] = e[2];
        flag_exp[uopf_pkg::FLAG_BUS_RESET] = h ? e[4] : e[3];
        flag_exp[uopf_pkg::FLAG_ERROR] = |(er & en);
    endfunction : flag_exp

    task automatic final_report;
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    always @(posedge aclk)
        if (adv === 1'b1)
            adv_cnt <= adv_cnt + 1;

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        repeat (10000) @(posedge aclk);
        errors++;
        final_report();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, attach, eng} = 8'h00;
        {awaddr, araddr, wdata, mode, ev, err, eie} = '0;
        errors = 0;
        num_checks = 0;
        v = $urandom(32'h1c057ef8);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("outputs", {cg, lp, po, an, sb}, 5'b01000);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("power reset", d, 32'h0);
        rd(uopf_pkg::OFF_INTERRUPT_FLAGS);
        chk("flags reset", d, {24'h0, uopf_pkg::FLAGS_RESET});
        rd(4'hc);
        chk("unmapped read", d, 32'h0);
        chk("unmapped read resp", r, 2'b10);
        wr(4'hc, $urandom());
        chk("unmapped write", r, 2'b10);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom();
            v[1:0] = i[1:0];
            wr(uopf_pkg::OFF_POWER_CONTROL, v);
            // no access while disabled and draining
            repeat (8) @(posedge aclk);
            rd(uopf_pkg::OFF_POWER_CONTROL);
            chk("power reg", d & (v[0] ? ~32'h8 : ~32'h0), v & 32'h13);
            chk("power pins", {cg, lp, po, an, sb}, {v[0] & !v[1], !v[0] | v[1], v[0], v[0],
                1'b0});
        end
        // engine idle: busy comes from the drain alone
        wr(uopf_pkg::OFF_POWER_CONTROL, 32'h1);
        wr(uopf_pkg::OFF_POWER_CONTROL, 32'h0);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("busy draining", d, 32'h8);
        eng <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("busy engine", d, 32'h8);
        eng <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("busy done", d, 32'h0);
        wr(uopf_pkg::OFF_POWER_CONTROL, 32'h11);
        mode <= 2'd3;
        repeat (6) @(posedge aclk);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("pending", d & ~32'h8, 32'h91);
        chk("sleep block", sb, 1'b1);
        mode <= 2'd0;
        pulse(6'h20, 8'h00);
        rd(uopf_pkg::OFF_POWER_CONTROL);
        chk("pending clear", d & ~32'h8, 32'h11);
        chk("sleep block", sb, 1'b0);
        wr(uopf_pkg::OFF_POWER_CONTROL, 32'h1);
        mode <= 2'd3;
        repeat (6) @(posedge aclk);
        chk("no guard", sb, 1'b0);
        mode <= 2'd0;
        pulse(6'h20, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            host = $urandom_range(1, 0);
            eie <= (i < 4) ? 8'h00 : 8'($urandom());
            wr(uopf_pkg::OFF_BUS_EVENT_CTRL, {31'h0, host});
            wr(uopf_pkg::OFF_INTERRUPT_FLAGS, 32'hff);
            v = $urandom();
            pulse({1'b0, v[12:8]}, v[7:0]);
            exp = flag_exp(v[12:8], host, v[7:0], eie);
            chk("flags", flags, exp);
            wr(uopf_pkg::OFF_INTERRUPT_FLAGS, v & 32'hffffff00);
            rd(uopf_pkg::OFF_INTERRUPT_FLAGS);
            chk("flags held", d, {24'h0, exp});
        end
        wr(uopf_pkg::OFF_BUS_EVENT_CTRL, 32'h0);
        wr(uopf_pkg::OFF_INTERRUPT_FLAGS, 32'hff);
        pulse(6'h1f, 8'h00);
        a0 = adv_cnt;
        wr(uopf_pkg::OFF_INTERRUPT_FLAGS, 32'h8);
        chk("single clear", flags, 8'h85);
        chk("fifo advance", adv_cnt - a0, 1);
        wr(uopf_pkg::OFF_INTERRUPT_FLAGS, 32'h85);
        chk("fifo advance", adv_cnt - a0, 1);
        chk("all clear", flags, 8'h00);
        // resume notification enable lives elsewhere and stays off here
        mode <= 2'd1;
        repeat (uopf_pkg::K_STATE_CYCLES - 10) @(posedge aclk);
        mode <= 2'd0;
        repeat (10) @(posedge aclk);
        chk("short k", flags[uopf_pkg::FLAG_RESUME], 1'b0);
        mode <= 2'd1;
        repeat (uopf_pkg::K_STATE_CYCLES + 5) @(posedge aclk);
        mode <= 2'd0;
        repeat (4) @(posedge aclk);
        chk("resume", flags[uopf_pkg::FLAG_RESUME], 1'b1);
        attach <= 1'b1;
        repeat (uopf_pkg::ATTACH_CYCLES + 10) @(posedge aclk);
        chk("attach device", flags[uopf_pkg::FLAG_ATTACH], 1'b0);
        wr(uopf_pkg::OFF_BUS_EVENT_CTRL, 32'h1);
        repeat (uopf_pkg::ATTACH_CYCLES + 10) @(posedge aclk);
        chk("attach host", flags[uopf_pkg::FLAG_ATTACH], 1'b1);
        attach <= 1'b0;
        final_report();
    end
endmodule : uopf_top_test
